// >>> can_node_core.sv
// CAN node core: bus-mode selection, deglitcher, fault confinement, APB
//
// How it works
// [RL1] Comparator output one means recessive; the code takes cmp_second_above_ref one as dominant
// [RL2] Mode code: diff, second, first, sleep
// [RL3] Differential: recessive when first above second
// [RL4] Single-wire: selected input against reference only
// [RL5] Drivers enabled per mode, none asleep
// [RL6] Reset enters differential, awaits calibration
// [RL7] Advance on bit overflow or counter 128
// [RL8] Mode change resets node, recalibrate first
// [RL9] Advance order zero, one, two, sleep
// [RL10] Sleep idles; dominant on either wakes
// [RL11] Four strap identifier bits latched at reset
// [RL12] Last identifier bit from message direction
// [RL13] Receive counter overflow means error passive
// [RL14] Transmit counter above 127 means passive
// [RL15] Transmit counter overflow means bus-off
// [RL16] Each detected error adds eight
// [RL17] CRC by polynomial division, sent, checked
// [RL18] Shift register holds identifier, data bytes
// [RL19] Corrupted transmission is retransmitted
// [RL20] All frames checked; error starts error frame
// [RL21] Valid frame decrements fault counters
// [RL22] Bit rate between 20 and 125 kbit/s
// [RL23] Comparator output held eight clocks after change
// [RL24] Calibration frames carry the fixed identifier
// [RL25] Calibration edges spaced 32 bit times
// [RL26] Waking returns to differential, recalibrates
// [RL27] Advance after more than 8191 bit times
`timescale 1ns/10ps
module can_node_core (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        cmp_first_above_second,
   input  wire logic        cmp_first_above_ref,
   input  wire logic        cmp_second_above_ref,
   input  wire logic [3:0]  node_identifier_straps,
   input  wire logic        cal_msg_done,
   input  wire logic        rx_bit_strobe,
   input  wire logic        tx_bit,
   input  wire logic        msg_from_node,
   input  wire logic        frame_ok,
   input  wire logic        err_detect,
   input  wire logic        err_in_tx,
   output logic             bus_level,
   output logic             bus_driver_first,
   output logic             bus_driver_second,
   output logic [1:0]       bus_mode,
   output logic             error_passive,
   output logic             bus_off,
   output logic             calibrated,
   output logic             retransmit,
   output logic             error_frame,
   output logic             node_reset,
   output logic [10:0]      node_identifier,
   output logic             id_match,
   output logic [15:0]      rx_data
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [14:0] crc_step(input logic [14:0] c,
                                            input logic b);
      logic fb;
      fb = b ^ c[14];
      crc_step = {c[13:0], 1'b0} ^ (fb ? can_node_pkg::CRC_POLY[14:0]
                                       : 15'h0000);
   endfunction

   function automatic logic [8:0] dec_sat(input logic [8:0] v);
      dec_sat = (v == 9'h000) ? v : v - 9'h001;
   endfunction

   can_node_pkg::state_t r;
   can_node_pkg::state_t next_r;

   logic [10:0] ident;
   logic        raw_level;
   logic        wake;
   logic        bit_tick;
   logic        advance;
   logic        passive;
   logic        boff;
   logic        access;
   logic [8:0]  rec_n;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_r = r;
      next_r.node_reset = 1'b0;
      next_r.retransmit = 1'b0;
      next_r.error_frame = 1'b0;
      // Pins pass two stages before anything reads them
      next_r.s1_cmp  = {cmp_second_above_ref, cmp_first_above_ref};
      next_r.s2_cmp  = r.s1_cmp;
      next_r.s1_diff = {r.s1_diff[0], cmp_first_above_second};
      next_r.s1_strap = node_identifier_straps;
      next_r.s2_strap = r.s1_strap;
      // Straps are caught once the synchroniser has filled
      if (!r.strap_taken) begin
         next_r.strap_wait = r.strap_wait + 2'h1;
         if (r.strap_wait == 2'h3) begin
            next_r.id_low = r.s2_strap; // RL11
            next_r.strap_taken = 1'b1;
         end
      end
      ident = {can_node_pkg::FIXED_ID, r.id_low, msg_from_node}; // RL12

      // One means recessive on every path below
      case (r.mode) // RL2
         can_node_pkg::MODE_DIFF:   raw_level = r.s1_diff[1]; // RL1 RL3
         can_node_pkg::MODE_SECOND: raw_level = ~r.s2_cmp[1]; // RL4
         can_node_pkg::MODE_FIRST:  raw_level = r.s2_cmp[0]; // RL4
         default:                   raw_level = 1'b1;
      endcase
      wake = (r.mode == can_node_pkg::MODE_SLEEP) &&
             (!r.s2_cmp[0] || r.s2_cmp[1]); // RL10

      // A change reaches the level at once, then the level holds for the hold window
      if (r.hold != 3'h0) begin
         next_r.hold = r.hold - 3'h1; // RL23
      end else if (raw_level != r.level) begin
         next_r.level = raw_level;
         next_r.hold  = can_node_pkg::HOLD_LOAD; // RL23
      end

      // Bit time divider; the rate register steers it
      bit_tick = 1'b0;
      if (r.mode != can_node_pkg::MODE_SLEEP) begin
         if (r.div_cnt >= r.div - 16'h0001) begin
            next_r.div_cnt = 16'h0000;
            bit_tick = 1'b1;
         end else begin
            next_r.div_cnt = r.div_cnt + 16'h0001;
         end
      end
      if (cal_msg_done) begin
         next_r.bit_cnt = 14'h0000;
         next_r.calibrated = 1'b1; // RL6 RL8
      end else if (bit_tick && r.bit_cnt <= can_node_pkg::BIT_LIMIT) begin
         next_r.bit_cnt = r.bit_cnt + 14'h0001; // RL27
      end

      // Fault confinement; an error in the same cycle as a good
      // frame wins, so the increment is never lost
      passive = r.receive_fault_counter[7] || (r.transmit_fault_counter > 9'h07f); // RL13 RL14
      boff = r.transmit_fault_counter[8]; // RL15
      rec_n = {1'b0, r.receive_fault_counter};
      if (err_detect && r.calibrated) begin
         next_r.error_frame = 1'b1; // RL20
         if (err_in_tx) begin
            next_r.transmit_fault_counter = (r.transmit_fault_counter > 9'h1f7) ? 9'h1ff
                                           : r.transmit_fault_counter + can_node_pkg::ERR_STEP;
            next_r.retransmit = ~boff; // RL19
         end else begin
            rec_n = rec_n + can_node_pkg::ERR_STEP; // RL16
            next_r.receive_fault_counter = (rec_n > 9'h0ff) ? 8'hff : rec_n[7:0];
         end
      end else if (frame_ok) begin
         next_r.transmit_fault_counter = dec_sat(r.transmit_fault_counter); // RL21
         next_r.receive_fault_counter = 8'(dec_sat({1'b0, r.receive_fault_counter})); // RL21
         next_r.data = r.shift[15:0]; // RL18
      end

      // Destuffed stream feeds shift register and checksum
      if (rx_bit_strobe) begin
         next_r.shift = {r.shift[30:0], r.level}; // RL18
         next_r.crc = crc_step(r.crc, r.level); // RL17
      end
      if (frame_ok || err_detect) begin
         next_r.crc = 15'h0000;
      end

      // Mode advance and wake both restart the node
      advance = (r.bit_cnt > can_node_pkg::BIT_LIMIT) ||
                r.receive_fault_counter[7] || (r.transmit_fault_counter >= 9'h080); // RL7
      if (wake || (advance && r.mode != can_node_pkg::MODE_SLEEP)) begin
         if (wake) begin
            next_r.mode = can_node_pkg::MODE_DIFF; // RL26
         end else begin
            next_r.mode = can_node_pkg::bus_mode_t'(r.mode + 2'h1); // RL9
         end
         next_r.node_reset = 1'b1; // RL8
         next_r.calibrated = 1'b0; // RL8
         next_r.bit_cnt = 14'h0000;
         next_r.div_cnt = 16'h0000;
         next_r.receive_fault_counter = 8'h00;
         next_r.transmit_fault_counter = 9'h000;
         next_r.shift = 32'h0000_0000;
         next_r.crc = 15'h0000;
         next_r.data = 16'h0000;
      end

      // Only a calibrated, on-bus node may drive dominant
      next_r.drv_first = 1'b0;
      next_r.drv_second = 1'b0;
      if (r.calibrated && !boff && !tx_bit) begin
         case (r.mode) // RL5
            can_node_pkg::MODE_DIFF: begin
               next_r.drv_first = 1'b1;
               next_r.drv_second = 1'b1;
            end
            can_node_pkg::MODE_SECOND: next_r.drv_second = 1'b1;
            can_node_pkg::MODE_FIRST:  next_r.drv_first = 1'b1;
            default: next_r.drv_first = 1'b0;
         endcase
      end

      // ****************************************
      // APB slave, answer in the first access cycle
      // ****************************************
      access = psel && penable && r.pready;
      next_r.pready = psel && !penable;
      if (psel && !penable) begin
         next_r.pslverr = 1'b0;
         case (paddr)
            can_node_pkg::OFS_CONTROL:
               next_r.prdata = {16'h0000, r.div};
            can_node_pkg::OFS_STATUS:
               next_r.prdata = {26'h000_0000, boff, passive, r.calibrated,
                                r.strap_taken, r.mode};
            can_node_pkg::OFS_COUNTERS:
               next_r.prdata = {7'h00, r.transmit_fault_counter, 8'h00, r.receive_fault_counter};
            can_node_pkg::OFS_IDENT:
               next_r.prdata = {1'b0, r.crc, 5'h00, ident};
            can_node_pkg::OFS_DATA:
               next_r.prdata = {16'h0000, r.data};
            default: begin
               next_r.prdata = 32'h0000_0000;
               next_r.pslverr = 1'b1;
            end
         endcase
      end
      if (access && pwrite && paddr == can_node_pkg::OFS_CONTROL) begin
         // Out-of-range rates are clamped to keep the node usable
         if (pwdata[15:0] < can_node_pkg::DIV_MIN) begin
            next_r.div = can_node_pkg::DIV_MIN; // RL22
         end else if (pwdata[15:0] > can_node_pkg::DIV_MAX) begin
            next_r.div = can_node_pkg::DIV_MAX; // RL22
         end else begin
            next_r.div = pwdata[15:0];
         end
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.s1_cmp <= 2'h1;
         r.s2_cmp <= 2'h1;
         r.s1_diff <= 2'h3;
         r.level <= 1'b1;
         r.mode <= can_node_pkg::MODE_DIFF; // RL6
         r.div <= can_node_pkg::DIV_DEF;
      end else begin
         r <= next_r;
      end
   end

   // ****************************************
   // Outputs, all from flops
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         node_identifier <= 11'h000;
         id_match <= 1'b0;
         error_passive <= 1'b0;
         bus_off <= 1'b0;
      end else begin
         node_identifier <= ident;
         // Accepts either direction bit for the node's own address
         id_match <= (r.shift[10:1] == ident[10:1]);
         error_passive <= passive;
         bus_off <= boff;
      end
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign bus_level = r.level;
   assign bus_driver_first = r.drv_first;
   assign bus_driver_second = r.drv_second;
   assign bus_mode = r.mode;
   assign calibrated = r.calibrated;
   assign retransmit = r.retransmit;
   assign error_frame = r.error_frame;
   assign node_reset = r.node_reset;
   assign rx_data = r.data;

endmodule

// >>> can_node_pkg.sv
// Shared constants and types for the CAN node bus-mode and fault logic
package can_node_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CLK_HZ       = 10_000_000;
   localparam int unsigned BIT_RATE_MIN = 20_000;
   localparam int unsigned BIT_RATE_MAX = 125_000;
   localparam int unsigned BIT_RATE_DEF = 125_000;
   localparam logic [15:0] DIV_MIN = 16'(CLK_HZ / BIT_RATE_MAX);
   localparam logic [15:0] DIV_MAX = 16'(CLK_HZ / BIT_RATE_MIN);
   localparam logic [15:0] DIV_DEF = 16'(CLK_HZ / BIT_RATE_DEF);
   localparam int unsigned GLITCH_CYCLES = 8;
   localparam logic [2:0]  HOLD_LOAD  = 3'(GLITCH_CYCLES - 1);
   localparam logic [13:0] BIT_LIMIT  = 14'h1fff;
   localparam logic [8:0]  ERR_STEP   = 9'h0008;
   // ****************************************
   // Bus modes
   // ****************************************
   typedef enum logic [1:0] {
      MODE_DIFF   = 2'h0,
      MODE_SECOND = 2'h1,
      MODE_FIRST  = 2'h2,
      MODE_SLEEP  = 2'h3
   } bus_mode_t;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] OFS_CONTROL  = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_COUNTERS = 8'h08;
   localparam logic [7:0] OFS_IDENT    = 8'h0c;
   localparam logic [7:0] OFS_DATA     = 8'h10;
   localparam logic [15:0] CRC_POLY    = 16'h4599;
   // Fixed upper identifier bits; value is arbitrary
   localparam logic [5:0] FIXED_ID     = 6'h15;
   localparam logic [10:0] CAL_ID      = 11'h0aa;
   typedef struct packed {
      logic [1:0]  s1_cmp;
      logic [1:0]  s2_cmp;
      logic [1:0]  s1_diff;
      logic [3:0]  s1_strap;
      logic [3:0]  s2_strap;
      logic [1:0]  strap_wait;
      logic        strap_taken;
      logic [3:0]  id_low;
      logic        level;
      logic [2:0]  hold;
      bus_mode_t   mode;
      logic [15:0] div;
      logic [15:0] div_cnt;
      logic [13:0] bit_cnt;
      logic        calibrated;
      logic [7:0]  receive_fault_counter;
      logic [8:0]  transmit_fault_counter;
      logic [31:0] shift;
      logic [14:0] crc;
      logic [15:0] data;
      logic        retransmit;
      logic        node_reset;
      logic        drv_first;
      logic        drv_second;
      logic        error_frame;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } state_t;
endpackage

// >>> can_far_node.sv
// Far-side model: the two-wire medium and the other nodes on it
`timescale 1ns/10ps
module can_far_node (
   input  wire logic dom_req,
   input  wire logic dead_first,
   input  wire logic dead_second,
   input  wire logic bus_driver_first,
   input  wire logic bus_driver_second,
   output logic      cmp_first_above_second,
   output logic      cmp_first_above_ref,
   output logic      cmp_second_above_ref
);
   logic dom;
   // Wired-AND medium: any driver pulls the line dominant
   assign dom = dom_req | bus_driver_first | bus_driver_second;
   // A dead wire floats recessive, so only the live wire carries a bit
   assign cmp_first_above_second = dead_first | dead_second | !dom;
   assign cmp_first_above_ref    = dead_first | !dom;
   assign cmp_second_above_ref   = !dead_second & dom;
endmodule

// >>> can_node_sva.sv
// Port checker for the CAN node core
`timescale 1ns/10ps
module can_node_sva (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       err_detect,
   input wire logic       err_in_tx,
   input wire logic       tx_bit,
   input wire logic       calibrated,
   input wire logic       bus_level,
   input wire logic       bus_driver_first,
   input wire logic       bus_driver_second,
   input wire logic [1:0] bus_mode,
   input wire logic       retransmit,
   input wire logic       error_frame
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_adv_order;
      $changed(bus_mode) && bus_mode != 2'h0
         |-> bus_mode == 2'($past(bus_mode) + 2'h1);
   endproperty
   property p_wake;
      $changed(bus_mode) && bus_mode == 2'h0 |-> $past(bus_mode) == 2'h3;
   endproperty
   property p_chg_uncal;
      $changed(bus_mode) |-> !calibrated;
   endproperty
   property p_sleep_drv;
      bus_mode == 2'h3 && $stable(bus_mode)
         |-> !bus_driver_first && !bus_driver_second;
   endproperty
   property p_mode1_drv;
      bus_mode == 2'h1 && $stable(bus_mode) |-> !bus_driver_first;
   endproperty
   property p_drv_cal;
      bus_driver_first || bus_driver_second
         |-> $past(calibrated) && !$past(tx_bit);
   endproperty
   property p_err_frame;
      err_detect && calibrated |=> error_frame;
   endproperty
   property p_retx;
      err_detect && err_in_tx && calibrated |=> retransmit ##1 !retransmit;
   endproperty
   property p_hold;
      $changed(bus_level) |=> $stable(bus_level) [*7];
   endproperty
   a_adv_order: assert property (p_adv_order) else $error("bad advance");
   a_wake: assert property (p_wake) else $error("bad return to mode 0");
   a_chg_uncal: assert property (p_chg_uncal) else $error("still cal");
   a_sleep_drv: assert property (p_sleep_drv) else $error("sleep drive");
   a_mode1_drv: assert property (p_mode1_drv) else $error("mode1 drive");
   a_drv_cal: assert property (p_drv_cal) else $error("uncal drive");
   a_err_frame: assert property (p_err_frame) else $error("no err frame");
   a_retx: assert property (p_retx) else $error("no retransmit");
   a_hold: assert property (p_hold) else $error("level not held");
   c_sleep: cover property (bus_mode == 2'h3);
   c_retx: cover property (retransmit);
   c_level: cover property ($fell(bus_level));
endmodule
bind can_node_core can_node_sva can_node_sva_i (.pclk(pclk),
   .presetn(presetn), .err_detect(err_detect), .err_in_tx(err_in_tx),
   .tx_bit(tx_bit), .calibrated(calibrated), .bus_level(bus_level),
   .bus_driver_first(bus_driver_first),
   .bus_driver_second(bus_driver_second), .bus_mode(bus_mode),
   .retransmit(retransmit), .error_frame(error_frame));

// >>> tb_top.sv
// Self-checking bench for the CAN node core
`timescale 1ns/10ps
module tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ef;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        c_fs, c_fr, c_sr, cal, strobe, tx_bit, frame_ok, err;
   logic        err_tx, dom_req, dead1, dead2, lvl, drv1, drv2;
   logic [3:0]  straps;
   logic [1:0]  mode;
   logic [15:0] rx_data;
   int          num_errors, n_checks;
   int          n_resets, n_passive, n_off;
   logic        epas, nrst, idm, boff, dir;
   logic [10:0] nid;
   // A frame whose identifier bits equal the node's own address
   localparam logic [15:0] ID_WORD = {5'h00, can_node_pkg::FIXED_ID, 4'ha,
                                      1'b0};
   can_node_core can_node_core_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmp_first_above_second(c_fs),
      .cmp_first_above_ref(c_fr), .cmp_second_above_ref(c_sr),
      .node_identifier_straps(straps), .cal_msg_done(cal),
      .rx_bit_strobe(strobe), .tx_bit(tx_bit), .msg_from_node(dir),
      .frame_ok(frame_ok), .err_detect(err), .err_in_tx(err_tx),
      .bus_level(lvl), .bus_driver_first(drv1), .bus_driver_second(drv2),
      .bus_mode(mode), .error_passive(epas), .bus_off(boff),
      .calibrated(), .retransmit(), .error_frame(), .node_reset(nrst),
      .node_identifier(nid), .id_match(idm), .rx_data(rx_data));
   can_far_node can_far_node_i (.dom_req(dom_req), .dead_first(dead1),
      .dead_second(dead2), .bus_driver_first(drv1),
      .bus_driver_second(drv2), .cmp_first_above_second(c_fs),
      .cmp_first_above_ref(c_fr), .cmp_second_above_ref(c_sr));
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      tick(1);
      penable <= 1'b1;
      tick(1);
      while (pready !== 1'b1) tick(1);
      rd = prdata;
      ef = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      tick(1);
   endtask
   task automatic errs(input int n, input logic tx);
      repeat (n) begin
         err    <= 1'b1;
         err_tx <= tx;
         tick(1);
         err    <= 1'b0;
         tick(1);
      end
   endtask
   task automatic calib;
      cal <= 1'b1;
      tick(1);
      cal <= 1'b0;
      tick(2);
   endtask
   task automatic level_chk(input string what);
      dom_req <= 1'b1;
      tick(14);
      check(what, 32'(lvl), 32'h0000_0000);
      dom_req <= 1'b0;
      tick(14);
      check(what, 32'(lvl), 32'h0000_0001);
   endtask
   task automatic drv_chk(input logic [1:0] exp);
      tx_bit <= 1'b0;
      tick(3);
      check("drivers", 32'({drv1, drv2}), 32'(exp));
      tx_bit <= 1'b1;
      tick(14);
   endtask
   // Sends a word MSB first, one strobe per settled bit
   task automatic shift_word(input logic [15:0] v);
      for (int i = 15; i >= 0; i--) begin
         dom_req <= ~v[i];
         tick(14);
         strobe  <= 1'b1;
         tick(1);
         strobe  <= 1'b0;
      end
      dom_req <= 1'b0;
   endtask
   // Reference checksum: division by the generator, MSB first
   function automatic logic [14:0] crc15(input logic [15:0] v);
      logic [14:0] c;
      c = 15'h0000;
      for (int i = 15; i >= 0; i--) begin
         c = {c[13:0], 1'b0} ^ ((v[i] ^ c[14]) ?
             can_node_pkg::CRC_POLY[14:0] : 15'h0000);
      end
      return c;
   endfunction
   // One-cycle pulses are counted so that none is missed
   always @(posedge pclk) begin
      n_resets  <= n_resets + int'(nrst);
      n_passive <= n_passive + int'(epas);
      n_off     <= n_off + int'(boff);
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   initial begin
      tick(20000);
      num_errors++;
      close_out();
   end
   initial begin
      {presetn, psel, penable, pwrite, cal, strobe, frame_ok} = 7'h00;
      {err, err_tx, dom_req, dead1, dead2, dir} = 6'h01;
      {paddr, pwdata, straps, tx_bit} = {8'h00, 32'h0000_0000, 4'ha, 1'b1};
      tick(16);
      presetn <= 1'b1;
      tick(8);
      check("mode", 32'(mode), 32'h0000_0000);
      apb(1'b0, can_node_pkg::OFS_IDENT, 32'h0000_0000);
      check("ident", rd & 32'h0000_07ff, 32'({can_node_pkg::FIXED_ID,
         4'ha, 1'b1}));
      apb(1'b0, 8'h20, 32'h0000_0000);
      check("unmapped", {rd[30:0], ef}, 32'h0000_0001);
      apb(1'b1, can_node_pkg::OFS_CONTROL, 32'h0000_0050);
      apb(1'b0, can_node_pkg::OFS_CONTROL, 32'h0000_0000);
      check("divider", rd, 32'h0000_0050);
      apb(1'b1, can_node_pkg::OFS_CONTROL, 32'h0000_ffff);
      apb(1'b0, can_node_pkg::OFS_CONTROL, 32'h0000_0000);
      check("div max", rd, 32'(can_node_pkg::DIV_MAX));
      apb(1'b1, can_node_pkg::OFS_CONTROL, 32'h0000_0001);
      apb(1'b0, can_node_pkg::OFS_CONTROL, 32'h0000_0000);
      check("div min", rd, 32'(can_node_pkg::DIV_MIN));
      level_chk("diff level");
      $display("reset and registers done");
      calib();
      apb(1'b0, can_node_pkg::OFS_STATUS, 32'h0000_0000);
      check("status cal", rd, 32'h0000_000c);
      drv_chk(2'b11);
      errs(1, 1'b1);
      shift_word(16'ha5c3);
      frame_ok <= 1'b1;
      tick(1);
      frame_ok <= 1'b0;
      tick(2);
      check("rx data", 32'(rx_data), 32'h0000_a5c3);
      check("no match", 32'(idm), 32'h0000_0000);
      apb(1'b0, can_node_pkg::OFS_DATA, 32'h0000_0000);
      check("data reg", rd, 32'h0000_a5c3);
      dir <= 1'b0;
      shift_word(ID_WORD);
      tick(2);
      check("match", 32'(idm), 32'h0000_0001);
      check("node id", 32'(nid), 32'(ID_WORD[10:0]));
      apb(1'b0, can_node_pkg::OFS_IDENT, 32'h0000_0000);
      check("ident dir", rd & 32'h0000_07ff, 32'(ID_WORD[10:0]));
      check("crc", 32'(rd[30:16]), 32'(crc15(ID_WORD)));
      apb(1'b0, can_node_pkg::OFS_COUNTERS, 32'h0000_0000);
      check("tec", rd, 32'h0007_0000);
      errs(15, 1'b1);
      apb(1'b0, can_node_pkg::OFS_STATUS, 32'h0000_0000);
      check("status 127", rd, 32'h0000_000c);
      errs(1, 1'b1);
      tick(3);
      check("mode 1", 32'(mode), 32'h0000_0001);
      apb(1'b0, can_node_pkg::OFS_STATUS, 32'h0000_0000);
      check("status m1", rd, 32'h0000_0005);
      $display("transmit faults done");
      dead1 <= 1'b1;
      level_chk("second wire");
      calib();
      drv_chk(2'b01);
      errs(15, 1'b0);
      apb(1'b0, can_node_pkg::OFS_COUNTERS, 32'h0000_0000);
      check("rec", rd, 32'h0000_0078);
      errs(1, 1'b0);
      tick(3);
      check("mode 2", 32'(mode), 32'h0000_0002);
      $display("receive faults done");
      dead1 <= 1'b0;
      dead2 <= 1'b1;
      level_chk("first wire");
      calib();
      drv_chk(2'b10);
      errs(16, 1'b1);
      tick(3);
      check("sleep", 32'({mode, drv1, drv2}), 32'h0000_000c);
      dead2   <= 1'b0;
      dom_req <= 1'b1;
      tick(8);
      check("wake", 32'(mode), 32'h0000_0000);
      dom_req <= 1'b0;
      $display("sleep and wake done");
      tick(14);
      check("resets", 32'(n_resets), 32'h0000_0004);
      check("passive", 32'(n_passive), 32'h0000_0003);
      check("bus off", 32'(n_off), 32'h0000_0000);
      close_out();
   end
endmodule
